// >>> rtl/pci_blank_map.vh
// Register offsets, field positions and reset values of the control-input block.
`ifndef PCI_BLANK_MAP_VH
`define PCI_BLANK_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets on the APB bus
// ----------------------------------------------------------------
`define ADDR_CFG_LOW_BASE 8'h00
`define ADDR_CFG_STRIDE 8'h08
`define ADDR_CFG_HIGH_OFS 8'h04
`define ADDR_BLANK_PERIOD 8'h20
`define ADDR_BLANK_EDGE 8'h24
`define ADDR_STATUS 8'h28

// ----------------------------------------------------------------
// Reset values and writable-bit masks
// ----------------------------------------------------------------
`define RESET_REG16 16'h0000
`define MASK_CFG_LOW 16'hff7f
`define MASK_CFG_HIGH 16'hf7ff
`define MASK_BLANK_PERIOD 16'hfff8
`define MASK_BLANK_EDGE 16'h070f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LOW_SW_TERM 7
`define HIGH_BYPASS_EN 15
`define EDGE_OUT_SEL_LSB 8

// ----------------------------------------------------------------
// Timing and build constants
// ----------------------------------------------------------------
`define BLANK_MIN_CLOCKS 16'h0008
`define GEN_PRESENT_MASK 8'h0f

`endif

// >>> rtl/pci_channel.v
// Acceptance, qualifier, latch and termination logic of one control input.
`timescale 1ns/1ps
`default_nettype none

module pci_channel
(
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // Configuration words.
    input wire [15:0] cfg_low,
    input wire [15:0] cfg_high,
    // Selected raw source and qualifier inputs.
    input wire src,
    input wire end_of_cycle,
    input wire duty_active,
    input wire blank_active,
    input wire gen_triggered,
    input wire gen_out_sel,
    input wire source_eight,
    input wire source_nine,
    input wire [2:0] trigger_event,
    input wire software_terminate,
    // Local control-input result.
    output reg result
);

// Qualifier source mux shared by acceptance and termination qualifiers.
function qual_mux;
    input [2:0] sel;
    input duty, blank, trig, gout, s8, s9;
    begin
        case (sel)
            3'h0: qual_mux = 1'b1;
            3'h1: qual_mux = duty;
            3'h2: qual_mux = blank;
            3'h3: qual_mux = trig;
            3'h4: qual_mux = gout;
            3'h5: qual_mux = s8;
            3'h6: qual_mux = s9;
            default: qual_mux = 1'b0;
        endcase
    end
endfunction

wire sw_bit = cfg_high[7];
wire [1:0] sw_mode = cfg_high[6:5];
wire [2:0] acceptance_criteria = cfg_high[10:8];
reg held; // Source sampled at end of cycle.
reg acc_prev; // Conditioned source one clock ago.
reg latch; // Set-reset latch of the latched modes.
reg pend; // Termination waiting for end of cycle.
reg next_result;
reg next_latch;
reg term_evt;

// Source optionally held to the end of the PWM cycle, then optionally inverted.
wire cond = (cfg_low[6] ? held : src) ^ cfg_low[5];
// The software bit is ORed in so a reset config leaves the source live.
wire acc_in = cond | (sw_mode == 2'b00 & sw_bit);
wire aq = (qual_mux(cfg_low[10:8], duty_active, blank_active, gen_triggered,
    gen_out_sel, source_eight, source_nine) ^ cfg_low[11])
    | (sw_mode == 2'b01 & sw_bit);
wire tq = (qual_mux(cfg_high[2:0], duty_active, blank_active, gen_triggered,
    gen_out_sel, source_eight, source_nine) ^ cfg_high[3])
    | (sw_mode == 2'b10 & sw_bit);
wire rise = acc_in & ~acc_prev;
wire any_edge = acc_in ^ acc_prev;
wire term_q = term_evt & tq;
// Immediate or end-of-cycle termination of a latched input.
wire term_fire = cfg_low[15] ? term_q : end_of_cycle & (pend | term_q);

// Termination event selection.
always @*
begin
    case (cfg_low[14:12])
        3'h0: term_evt = software_terminate;
        3'h1: term_evt = acc_prev & ~acc_in;
        3'h2: term_evt = trigger_event[0];
        3'h3: term_evt = trigger_event[1];
        3'h4: term_evt = trigger_event[2];
        3'h5: term_evt = gen_out_sel;
        3'h6: term_evt = source_eight;
        default: term_evt = source_nine;
    endcase
end

// Acceptance decode and latch dominance.
always @*
begin
    next_latch = 1'b0;
    next_result = 1'b0;
    case (acceptance_criteria)
        3'h0: next_result = acc_in & aq;
        3'h1: next_result = rise & aq;
        3'h2: next_result = any_edge & aq;
        3'h3, 3'h4, 3'h5:
        begin
            if (cfg_high[4])
                next_latch = term_fire ? 1'b0 : (set_in(acceptance_criteria) | latch);
            else
                next_latch = set_in(acceptance_criteria) | (latch & ~term_fire);
            next_result = next_latch;
        end
        default: next_result = 1'b0;
    endcase
end

// Set input of the latch for each latched mode.
function set_in;
    input [2:0] mode;
    begin
        set_in = (mode == 3'h3) ? acc_in & aq :
            (mode == 3'h4) ? rise & aq : any_edge & aq;
    end
endfunction

// State registers.
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        held <= 1'b0;
        acc_prev <= 1'b0;
        latch <= 1'b0;
        pend <= 1'b0;
        result <= 1'b0;
    end
    else
    begin
        if (end_of_cycle)
            held <= src;
        acc_prev <= acc_in;
        latch <= next_latch;
        pend <= ~end_of_cycle & (pend | term_q);
        result <= next_result;
    end
end

endmodule // pci_channel

`default_nettype wire

// >>> rtl/blank_timer.v
// Leading-edge blanking counter triggered by chosen output edges.
`timescale 1ns/1ps
`default_nettype none
`include "pci_blank_map.vh"

module blank_timer
(
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // Own generator outputs and configuration.
    input wire high_side_output,
    input wire low_side_output,
    input wire [3:0] edge_enable,
    input wire [15:0] period,
    // Blanking status.
    output reg blank_active
);

reg prev_high; // High side one clock ago.
reg prev_low; // Low side one clock ago.
reg [15:0] count; // Clocks of blanking still to run.

// Enabled edges: bit 3 high rise down to bit 0 low fall.
wire trig = |(edge_enable & {high_side_output & ~prev_high,
    ~high_side_output & prev_high, low_side_output & ~prev_low,
    ~low_side_output & prev_low});
// Three low bits dropped; zero upper field still blanks eight clocks.
wire [15:0] load = (period[15:3] == 13'h0000) ? `BLANK_MIN_CLOCKS :
    {period[15:3], 3'b000};

// Counter restarts on any enabled edge and runs down to zero.
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prev_high <= 1'b0;
        prev_low <= 1'b0;
        count <= 16'h0000;
        blank_active <= 1'b0;
    end
    else
    begin
        prev_high <= high_side_output;
        prev_low <= low_side_output;
        if (trig)
        begin
            count <= load;
            blank_active <= 1'b1;
        end
        else if (count != 16'h0000)
        begin
            count <= count - 16'h0001;
            blank_active <= (count != 16'h0001);
        end
    end
end

endmodule // blank_timer

`default_nettype wire

// >>> rtl/pwm_control_input_blanking.v
// Control-input conditioning and blanking for one PWM generator, with APB registers.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pci_blank_map.vh"

// Contract
// - Four instances: fault, limit, feed-forward, sync.
// - Five-bit source select: zero, mux, combos, inputs.
// - Bypass uses chosen generator's control-input result.
// - Bypass codes pick generators one to eight.
// - Absent generator selections return zero.
// - Acceptance: level, edges, latched variants decode.
// - Software bit drives the selected logic point.
// - Software mode routes to acceptance or qualifiers.
// - Latch mode picks reset or set dominance.
// - Termination qualifier has optional inverter.
// - Termination qualifier source eight-way decode.
// - Blanking period ignores three low bits.
// - Zero period field gives eight clock blanking.
// - Blanking low three bits read zero.
// - Selector offers generator output as source one.
// - Four enables choose blanking restart edges.
// - Selected generator output never touches blanking.
// - Manual and auto termination selections.
// - Optional sync of source to cycle end.
// - Latched termination immediate or at cycle end.
// - Source polarity inverter before acceptance.
module pwm_control_input_blanking
(
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Asynchronous pins: dedicated, remappable, comparators.
    input wire [3:0] device_pin,
    input wire [10:0] remappable_input,
    input wire [2:0] comparator,
    // On-chip sources in the generator clock domain.
    input wire [1:0] combo_trigger,
    input wire [3:0] pwm_event,
    input wire configurable_logic_cell_one,
    input wire [7:0] generator_outputs,
    input wire [31:0] peer_results,
    // Own generator status.
    input wire high_side_output,
    input wire low_side_output,
    input wire duty_active,
    input wire generator_triggered,
    input wire end_of_cycle,
    input wire [2:0] trigger_event,
    input wire source_eight,
    input wire source_nine,
    // Results.
    output reg [3:0] control_active,
    output wire [3:0] local_result,
    output wire blanking_active
);

// ----------------------------------------------------------------
// Register storage
// ----------------------------------------------------------------

reg [15:0] cfg_low [0:3]; // Low configuration word per instance.
reg [15:0] cfg_high [0:3]; // High configuration word per instance.
reg [15:0] blanking_period; // Blanking length, low bits kept zero.
reg [15:0] blank_edge_sel; // Output select and edge enables.
reg [3:0] sw_term_pulse; // One-clock software terminate strobes.
reg [31:0] next_prdata;
reg addr_ok;

// ----------------------------------------------------------------
// APB decode
// ----------------------------------------------------------------

// Zero wait states: read data is captured in the setup cycle, so the
// access phase can answer at once while prdata still comes from a flop.
assign pready = 1'b1;
wire access = psel & penable;
wire do_write = access & pwrite;
assign pslverr = access & ~addr_ok;

// Instance index and word half from the address.
wire [1:0] inst = paddr[4:3];
wire is_high = paddr[2];

// Status word shows the block's own live state.
wire [31:0] status_word = {23'h000000, blanking_active,
    local_result, control_active};

// Address decode and read mux.
always @*
begin
    addr_ok = 1'b1;
    next_prdata = 32'h00000000;
    if (paddr[1:0] != 2'b00)
        addr_ok = 1'b0;
    else if (paddr < `ADDR_BLANK_PERIOD)
    begin
        // Software terminate bit is write-only and reads back zero.
        if (is_high)
            next_prdata = {16'h0000, cfg_high[inst]};
        else
            next_prdata = {16'h0000, cfg_low[inst]};
    end
    else if (paddr == `ADDR_BLANK_PERIOD)
        next_prdata = {16'h0000, blanking_period};
    else if (paddr == `ADDR_BLANK_EDGE)
        next_prdata = {16'h0000, blank_edge_sel};
    else if (paddr == `ADDR_STATUS)
        next_prdata = status_word;
    else
        addr_ok = 1'b0;
end

// Read data register, loaded in the setup cycle.
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        prdata <= 32'h00000000;
    else if (psel & ~penable & ~pwrite)
        prdata <= next_prdata;
end

// ----------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------

// One process per instance keeps each array entry single-driven.
genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_cfg
        wire hit = do_write & (paddr < `ADDR_BLANK_PERIOD)
            & (paddr[1:0] == 2'b00) & (inst == gi);
        // Config words; reserved bits and the terminate strobe not stored.
        always @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                cfg_low[gi] <= `RESET_REG16;
                cfg_high[gi] <= `RESET_REG16;
                sw_term_pulse[gi] <= 1'b0;
            end
            else
            begin
                sw_term_pulse[gi] <= hit & ~is_high
                    & pwdata[`LOW_SW_TERM];
                if (hit & is_high)
                    cfg_high[gi] <= pwdata[15:0] & `MASK_CFG_HIGH;
                else if (hit)
                    cfg_low[gi] <= pwdata[15:0] & `MASK_CFG_LOW;
            end
        end
    end
endgenerate

// Blanking registers; low period bits are forced to zero on write.
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        blanking_period <= `RESET_REG16;
        blank_edge_sel <= `RESET_REG16;
    end
    else if (do_write & (paddr == `ADDR_BLANK_PERIOD))
        blanking_period <= pwdata[15:0] & `MASK_BLANK_PERIOD;
    else if (do_write & (paddr == `ADDR_BLANK_EDGE))
        blank_edge_sel <= pwdata[15:0] & `MASK_BLANK_EDGE;
end

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------

reg [17:0] pin_meta; // First stage, read only by the second.
reg [17:0] pin_sync; // Second stage, safe for logic.

// Two flops on every asynchronous input. This adds two clocks of
// latency to pin and comparator sources, traded for metastability.
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pin_meta <= 18'h00000;
        pin_sync <= 18'h00000;
    end
    else
    begin
        pin_meta <= {comparator, device_pin, remappable_input};
        pin_sync <= pin_meta;
    end
end

// ----------------------------------------------------------------
// Generator output selector
// ----------------------------------------------------------------

wire [7:0] present = `GEN_PRESENT_MASK;
wire [2:0] out_sel = blank_edge_sel[`EDGE_OUT_SEL_LSB +: 3];
// Feeds only the control inputs, never the blanking counter.
wire gen_out_sel = generator_outputs[out_sel] & present[out_sel];

// ----------------------------------------------------------------
// Source vector indexed by the five-bit source select
// ----------------------------------------------------------------

// Reserved codes stay tied low.
wire [31:0] src_vec = {configurable_logic_cell_one, 1'b0,
    pin_sync[17:15], pwm_event, pin_sync[14:11], pin_sync[10:0],
    4'h0, combo_trigger, gen_out_sel, 1'b0};

// ----------------------------------------------------------------
// Leading-edge blanking
// ----------------------------------------------------------------

blank_timer u_blank
(
    .pclk(pclk),
    .presetn(presetn),
    .high_side_output(high_side_output),
    .low_side_output(low_side_output),
    .edge_enable(blank_edge_sel[3:0]),
    .period(blanking_period),
    .blank_active(blanking_active)
);

// ----------------------------------------------------------------
// Four control-input instances
// ----------------------------------------------------------------

// Index 0 fault, 1 current limit, 2 feed-forward, 3 sync.
genvar ci;
generate
    for (ci = 0; ci < 4; ci = ci + 1)
    begin : g_pci
        wire [15:0] lo = cfg_low[ci];
        wire [15:0] hi = cfg_high[ci];
        wire [2:0] bp_sel = hi[14:12];
        // Peer result of the same instance kind in the chosen generator.
        wire peer = peer_results[{bp_sel, 2'b00} + ci] & present[bp_sel];

        pci_channel u_chan
        (
            .pclk(pclk),
            .presetn(presetn),
            .cfg_low(lo),
            .cfg_high(hi),
            .src(src_vec[lo[4:0]]),
            .end_of_cycle(end_of_cycle),
            .duty_active(duty_active),
            .blank_active(blanking_active),
            .gen_triggered(generator_triggered),
            .gen_out_sel(gen_out_sel),
            .source_eight(source_eight),
            .source_nine(source_nine),
            .trigger_event(trigger_event),
            .software_terminate(sw_term_pulse[ci]),
            .result(local_result[ci])
        );

        // Bypass swaps the local result for the peer's; registered so the
        // output is glitch free, at the cost of one clock of latency.
        always @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                control_active[ci] <= 1'b0;
            else if (hi[`HIGH_BYPASS_EN])
                control_active[ci] <= peer;
            else
                control_active[ci] <= local_result[ci];
        end
    end
endgenerate

endmodule // pwm_control_input_blanking

`default_nettype wire

// >>> verif/pci_blank_properties.sv
// Port-level checker for the control-input and blanking block.
`timescale 1ns/1ps
`default_nettype none

module pci_blank_properties
(
    // Clock, reset and bus.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Sources and results.
    input wire logic [1:0] combo_trigger,
    input wire logic high_side_output,
    input wire logic low_side_output,
    input wire logic [3:0] local_result,
    input wire logic blanking_active
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Shadow registers, taken when a write completes.
    // ------------------------------------------------------------
    logic [15:0] lo0, hi0, per, edg;
    logic ph, pl;
    logic [15:0] run; // Blanking cycles since the last edge.
    wire wr = psel && penable && pwrite;
    // Enabled edge against the previous clock.
    wire trig = (edg[3] && high_side_output && !ph) || (edg[2] && !high_side_output && ph)
        || (edg[1] && low_side_output && !pl) || (edg[0] && !low_side_output && pl);
    wire [15:0] blen = (per[15:3] == 13'h0000) ? 16'h0008 : {per[15:3], 3'b000};

    // Shadows of the stored settings.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {lo0, hi0, per, edg, run, ph, pl} <= 82'h0;
        else
        begin
            ph <= high_side_output;
            pl <= low_side_output;
            run <= trig ? 16'h0000 : (blanking_active ? run + 16'h0001 : run);
            if (wr && paddr == 8'h00)
                lo0 <= pwdata[15:0] & 16'hff7f;
            if (wr && paddr == 8'h04)
                hi0 <= pwdata[15:0] & 16'hf7ff;
            if (wr && paddr == 8'h20)
                per <= pwdata[15:0];
            if (wr && paddr == 8'h24)
                edg <= pwdata[15:0];
        end
    end

    sequence s_level_cfg;
        lo0 == 16'h0002 && hi0 == 16'h0000;
    endsequence
    sequence s_zero_cfg;
        lo0 == 16'h0000 && hi0 == 16'h0000;
    endsequence

    property p_blank_high;
        (edg[3] && $rose(high_side_output)) || (edg[2] && $fell(high_side_output)) |=> blanking_active;
    endproperty
    a_blank_high: assert property (p_blank_high) else $error("blanking missed a high-side edge");
    property p_blank_low;
        (edg[1] && $rose(low_side_output)) || (edg[0] && $fell(low_side_output)) |=> blanking_active;
    endproperty
    a_blank_low: assert property (p_blank_low) else $error("blanking missed a low-side edge");
    property p_blank_quiet;
        !blanking_active && !trig |=> !blanking_active;
    endproperty
    a_blank_quiet: assert property (p_blank_quiet) else $error("blanking with no enabled edge");
    property p_blank_len;
        $fell(blanking_active) |-> run == blen;
    endproperty
    a_blank_len: assert property (p_blank_len) else $error("blanking ended at the wrong count");
    property p_blank_max;
        blanking_active |-> run < blen;
    endproperty
    a_blank_max: assert property (p_blank_max) else $error("blanking outlasted its period");
    property p_period_low;
        psel && penable && !pwrite && paddr == 8'h20 |-> prdata[2:0] == 3'b000;
    endproperty
    a_period_low: assert property (p_period_low) else $error("period low bits read nonzero");
    property p_zero_src;
        s_zero_cfg [*3] |-> local_result[0] == 1'b0;
    endproperty
    a_zero_src: assert property (p_zero_src) else $error("zero source gave a result");
    property p_level;
        s_level_cfg [*3] |-> local_result[0] == $past(combo_trigger[0]);
    endproperty
    a_level: assert property (p_level) else $error("level mode missed source");
endmodule // pci_blank_properties

`default_nettype wire

// >>> verif/pwm_far_side.sv
// Model of own and neighbouring generator outputs.
`timescale 1ns/1ps
`default_nettype none

module pwm_far_side
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Commands from the bench.
    input wire logic run,
    input wire logic level,
    // Generator outputs and peer results.
    output logic high_side_output,
    output logic low_side_output,
    output logic [7:0] generator_outputs,
    output logic [31:0] peer_results
);
    logic [5:0] cnt; // Half-period counter.

    // High side toggles every 40 clocks, past any tested blanking.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn || !run)
        begin
            cnt <= 6'h00;
            high_side_output <= 1'b0;
        end
        else if (cnt == 6'h27)
        begin
            cnt <= 6'h00;
            high_side_output <= !high_side_output;
        end
        else
            cnt <= cnt + 6'h01;
    end

    // Low side complements high while running; both idle low.
    assign low_side_output = run && !high_side_output;
    assign generator_outputs = {8{level}};
    assign peer_results = {32{level}};
endmodule // pwm_far_side

`default_nettype wire

// >>> verif/pwm_control_input_blanking_test.sv
// Self-checking bench for the control-input and blanking block.
`timescale 1ns/1ps
`default_nettype none

module pwm_control_input_blanking_test;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, lvl, run, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, rd;
    wire [31:0] prdata, peer_results;
    wire pready, pslverr, high_side_output, low_side_output, blanking_active;
    wire [7:0] generator_outputs;
    wire [3:0] control_active, local_result;
    int err_count = 0, checked = 0, cyc = 0, m;
    logic [7:0] ra [0:4] = '{8'h00, 8'h04, 8'h20, 8'h24, 8'h40};
    logic [15:0] rx [0:4] = '{16'hff7f, 16'hf7ff, 16'hfff8, 16'h070f, 16'h0000};
    logic [15:0] be [0:2] = '{16'h0008, 16'h0001, 16'h0004};
    logic [15:0] bp [0:2] = '{16'h0000, 16'h0018, 16'h000f};
    int bl [0:2] = '{8, 24, 8};

    // All sources follow lvl.
    pwm_control_input_blanking u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .device_pin({4{lvl}}),
        .remappable_input({11{lvl}}), .comparator({3{lvl}}), .combo_trigger({2{lvl}}),
        .pwm_event({4{lvl}}), .configurable_logic_cell_one(lvl), .generator_outputs,
        .peer_results, .high_side_output, .low_side_output, .duty_active(high_side_output),
        .generator_triggered(low_side_output), .end_of_cycle(1'b0), .trigger_event(3'b000),
        .source_eight(lvl), .source_nine(lvl), .control_active, .local_result,
        .blanking_active);
    pwm_far_side u_far (.pclk, .presetn, .run, .level(lvl), .high_side_output,
        .low_side_output, .generator_outputs, .peer_results);

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // A hang ends at this ceiling.
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_count++;
            conclude();
        end
    end

    // One APB transfer, begun just after an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic conclude();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        {presetn, psel, penable, pwrite, lvl, run, paddr, pwdata} = 46'h0;
        tick(6);
        presetn <= 1'b1;
        tick(1);
        // Reset values, writable masks and the unmapped word.
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, ra[i], 16'h0000);
            chk("reset value", rd, 32'h0000_0000);
            apb(1'b1, ra[i], 16'hffff);
            apb(1'b0, ra[i], 16'h0000);
            chk("register", rd, {16'h0000, rx[i]});
            chk("slave error", er, i == 4);
            apb(1'b1, ra[i], 16'h0000);
        end
        // All sources high; reserved codes stay low.
        lvl <= 1'b1;
        for (int c = 0; c < 32; c++)
        begin
            apb(1'b1, 8'h00, 16'(c));
            tick(6);
            chk("source", control_active[0], (c >= 8 && c != 30) || (c >= 1 && c <= 3));
        end
        // Output select and bypass over eight generators, four absent.
        apb(1'b1, 8'h00, 16'h0001);
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b1, 8'h24, {5'h00, 3'(k), 8'h00});
            apb(1'b1, 8'h04, {1'b1, 3'(k), 12'h000});
            tick(4);
            chk("output select", local_result[0], k < 4);
            chk("bypass", control_active[0], k < 4);
        end
        lvl <= 1'b0;
        apb(1'b1, 8'h04, 16'h0000);
        apb(1'b1, 8'h24, 16'h0000);
        apb(1'b1, 8'h00, 16'h0002);
        tick(4);
        apb(1'b1, 8'h00, 16'h0022);
        tick(4);
        chk("inverted source", control_active[0], 1'b1);
        apb(1'b1, 8'h00, 16'h0002);
        apb(1'b1, 8'h04, 16'h0080);
        tick(4);
        chk("software bit", control_active[0], 1'b1);
        // A one-clock pulse latches; software terminate clears it.
        apb(1'b1, 8'h04, 16'h0300);
        apb(1'b1, 8'h00, 16'h8002);
        lvl <= 1'b1;
        tick(1);
        lvl <= 1'b0;
        tick(6);
        chk("latched", control_active[0], 1'b1);
        apb(1'b1, 8'h00, 16'h8082);
        tick(4);
        chk("terminated", control_active[0], 1'b0);
        apb(1'b1, 8'h04, 16'h0000);
        apb(1'b1, 8'h00, 16'h0000);
        // Blanking length for several edges and periods.
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, 8'h20, bp[i]);
            apb(1'b1, 8'h24, be[i]);
            run <= 1'b1;
            for (m = 0; blanking_active !== 1'b1 && m < 200; m++)
                @(posedge pclk);
            for (m = 0; blanking_active === 1'b1 && m < 200; m++)
                @(posedge pclk);
            chk("blanking length", m, bl[i]);
            run <= 1'b0;
            tick(100);
        end
        // No edge enabled: blanking stays off.
        apb(1'b1, 8'h24, 16'h0000);
        run <= 1'b1;
        m = 0;
        repeat (120)
        begin
            @(posedge pclk);
            lvl <= !lvl;
            if (blanking_active === 1'b1)
                m++;
        end
        chk("blanking idle", m, 0);
        conclude();
    end
endmodule // pwm_control_input_blanking_test

bind pwm_control_input_blanking pci_blank_properties u_props (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .combo_trigger, .high_side_output,
    .low_side_output, .local_result, .blanking_active);

`default_nettype wire
